// ---- include/panel_pkg.sv ----
// Purpose: constants for the front-panel display scan and button logic
// Assumes: 200 MHz core clock
// Notes: tick periods are rounded down to whole cycles
package panel_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SCAN_TICK_HZ = 1000;
  localparam int unsigned SCAN_TICK_CYCLES = CLK_HZ / SCAN_TICK_HZ;
  localparam int unsigned UPDATE_TICK_HZ = 97;
  localparam int unsigned UPDATE_TICK_CYCLES = CLK_HZ / UPDATE_TICK_HZ;
  localparam int unsigned UPDATE_DIVIDE = 32;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned UNIT_COUNT = 4;
  localparam int unsigned ADC_WIDTH = 8;
  // Enable bit positions
  localparam int unsigned EN_DISCRETE = 0;
  localparam int unsigned EN_TENTHS = 1;
  localparam int unsigned EN_ONES = 2;
  localparam int unsigned EN_TENS = 3;
  // Discrete indicator bit positions on the shared bus
  localparam int unsigned IND_AIRFLOW = 0;
  localparam int unsigned IND_TEMPERATURE = 1;
  localparam int unsigned IND_PRESSURE = 2;
  localparam int unsigned IND_SETPOINT = 3;
  // Analog channel assignment
  localparam logic [2:0] CH_PRESSURE = 3'h0;
  localparam logic [2:0] CH_TEMPERATURE = 3'h1;
  localparam logic [2:0] CH_SETPOINT = 3'h2;
  localparam logic [7:0] SEG_BUS_RESET = 8'h00;
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  typedef enum logic [1:0] {
    PARAM_AIRFLOW = 2'b00,
    PARAM_TEMPERATURE = 2'b01,
    PARAM_PRESSURE = 2'b10,
    PARAM_SETPOINT = 2'b11
  } param_e;
  typedef enum logic [1:0] {
    UNIT_DISCRETE = 2'b00,
    UNIT_TENTHS = 2'b01,
    UNIT_ONES = 2'b10,
    UNIT_TENS = 2'b11
  } unit_e;
endpackage

// ---- hw/tick_gen.sv ----
// Purpose: periodic one-cycle tick from the core clock
// Assumes: PERIOD of at least 2
// Notes: none
`timescale 1ns/10ps
module tick_gen #(
  parameter int unsigned PERIOD = 200000
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic tick
);
  localparam int unsigned W = $clog2(PERIOD);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    tick = (cnt_q == W'(PERIOD - 1));
    cnt_d = tick ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ---- hw/front_panel_led_mux_io.sv ----
// Purpose: front-panel display scan, button decode and setpoint relay
// Assumes: inputs synchronous to core_clk; analog values and airflow come from outside
// Notes: digit patterns are supplied already segment-encoded
// Function
// - One shared eight-line bus is time-multiplexed over three digits and the LED group, one unit enabled at a time.
// - Bus bits 0..7 are segments A..G and the point; bits 0..3 light airflow, temperature, pressure, setpoint LEDs.
// - Separate enables select the LED group, the tenths, the ones and the tens digit.
// - Only the indicator of the parameter being shown is lit.
// - Two active-low buttons decode to airflow, temperature, pressure or setpoint, setpoint winning.
// - Buttons are not latched or debounced; the selection follows line levels at the update rate.
// - The relay output is a plain output asserted on a setpoint violation.
// - The five shared analog lines change mode only together and stay readable as digital inputs.
// - Analog channel 0 is pressure, 1 is temperature, 2 is the setpoint pot.
// - A tick of about 1 kHz advances the scan, each unit refreshed every fourth tick.
// - On each scan tick the old unit is disabled before the new data is loaded and enabled.
// - A 97 Hz tick is counted and every 32nd sets the update flag; display and selection change only then.
// - The relay closes when airflow exceeds setpoint and opens otherwise, each measurement pass.
`timescale 1ns/10ps
module front_panel_led_mux_io
  import panel_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = SCAN_TICK_CYCLES,
  parameter int unsigned UPDATE_CYCLES = UPDATE_TICK_CYCLES,
  parameter int unsigned UPDATE_COUNT = UPDATE_DIVIDE
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic temperature_select_button_n,
  input wire logic pressure_select_button_n,
  input wire logic tach_pulse_n,
  input wire logic analog_mode,
  input wire logic [4:0] shared_port_pins,
  input wire logic [7:0] airflow_segments [3],
  input wire logic [7:0] temperature_segments [3],
  input wire logic [7:0] pressure_segments [3],
  input wire logic [7:0] setpoint_segments [3],
  input wire logic [ADC_WIDTH-1:0] airflow_value,
  input wire logic [ADC_WIDTH-1:0] setpoint_value,
  input wire logic measure_done,
  output logic [DATA_WIDTH-1:0] segment_bus,
  output logic [UNIT_COUNT-1:0] unit_enable,
  output logic setpoint_relay,
  output logic tach_edge_interrupt,
  output logic [4:0] shared_port_digital,
  output logic shared_port_analog,
  output logic [2:0] pressure_channel,
  output logic [2:0] temperature_channel,
  output logic [2:0] setpoint_channel,
  output param_e shown_param
);
  localparam int unsigned UW = $clog2(UPDATE_COUNT);

  function automatic param_e decode_buttons(input logic temp_n, input logic press_n);
    param_e p;
    case ({temp_n, press_n})
      2'b11: p = PARAM_AIRFLOW;
      2'b01: p = PARAM_TEMPERATURE;
      2'b10: p = PARAM_PRESSURE;
      2'b00: p = PARAM_SETPOINT;
      default: p = PARAM_AIRFLOW;
    endcase
    return p;
  endfunction

  function automatic logic [7:0] indicator_for(input param_e p);
    logic [7:0] v;
    v = 8'h00;
    case (p)
      PARAM_AIRFLOW: v[IND_AIRFLOW] = 1'b1;
      PARAM_TEMPERATURE: v[IND_TEMPERATURE] = 1'b1;
      PARAM_PRESSURE: v[IND_PRESSURE] = 1'b1;
      PARAM_SETPOINT: v[IND_SETPOINT] = 1'b1;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  logic scan_tick;
  logic slow_tick;

  tick_gen #(.PERIOD(SCAN_CYCLES)) u_scan_tick (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(scan_tick)
  );

  tick_gen #(.PERIOD(UPDATE_CYCLES)) u_update_tick (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(slow_tick)
  );

  // Scan state
  unit_e unit_q, unit_d;
  logic blank_q, blank_d;
  logic [DATA_WIDTH-1:0] bus_q, bus_d;
  logic [UNIT_COUNT-1:0] en_q, en_d;
  // Update state
  logic [UW-1:0] slow_cnt_q, slow_cnt_d;
  logic update_q, update_d;
  param_e param_q, param_d;
  logic [7:0] shown_q [3];
  logic [7:0] shown_d [3];
  // Relay and tach state
  logic relay_q, relay_d;
  logic tach_prev_q, tach_prev_d;
  logic tach_irq_q, tach_irq_d;

  always_comb begin
    unit_d = unit_q;
    blank_d = 1'b0;
    bus_d = bus_q;
    en_d = en_q;
    if (scan_tick) begin
      en_d = ENABLES_RESET;
      blank_d = 1'b1;
    end else if (blank_q) begin
      case (unit_q)
        UNIT_DISCRETE: bus_d = indicator_for(param_q);
        UNIT_TENTHS: bus_d = shown_q[0];
        UNIT_ONES: bus_d = shown_q[1];
        UNIT_TENS: bus_d = shown_q[2];
        default: bus_d = SEG_BUS_RESET;
      endcase
      en_d = ENABLES_RESET;
      case (unit_q)
        UNIT_DISCRETE: en_d[EN_DISCRETE] = 1'b1;
        UNIT_TENTHS: en_d[EN_TENTHS] = 1'b1;
        UNIT_ONES: en_d[EN_ONES] = 1'b1;
        UNIT_TENS: en_d[EN_TENS] = 1'b1;
        default: en_d = ENABLES_RESET;
      endcase
      unit_d = unit_e'(unit_q + 2'h1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      unit_q <= UNIT_DISCRETE;
      blank_q <= 1'b0;
      bus_q <= SEG_BUS_RESET;
      en_q <= ENABLES_RESET;
    end else begin
      unit_q <= unit_d;
      blank_q <= blank_d;
      bus_q <= bus_d;
      en_q <= en_d;
    end
  end

  always_comb begin
    slow_cnt_d = slow_cnt_q;
    update_d = 1'b0;
    param_d = param_q;
    shown_d = shown_q;
    if (slow_tick) begin
      slow_cnt_d = (slow_cnt_q == UW'(UPDATE_COUNT - 1)) ? '0 : slow_cnt_q + UW'(1);
      update_d = (slow_cnt_q == UW'(UPDATE_COUNT - 1));
    end
    if (update_q) begin
      param_d = decode_buttons(temperature_select_button_n, pressure_select_button_n);
      for (int i = 0; i < 3; i++) begin
        case (param_d)
          PARAM_AIRFLOW: shown_d[i] = airflow_segments[i];
          PARAM_TEMPERATURE: shown_d[i] = temperature_segments[i];
          PARAM_PRESSURE: shown_d[i] = pressure_segments[i];
          PARAM_SETPOINT: shown_d[i] = setpoint_segments[i];
          default: shown_d[i] = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slow_cnt_q <= '0;
      update_q <= 1'b0;
      param_q <= PARAM_AIRFLOW;
      for (int i = 0; i < 3; i++) begin
        shown_q[i] <= 8'h00;
      end
    end else begin
      slow_cnt_q <= slow_cnt_d;
      update_q <= update_d;
      param_q <= param_d;
      shown_q <= shown_d;
    end
  end

  always_comb begin
    relay_d = relay_q;
    if (measure_done) begin
      relay_d = (airflow_value > setpoint_value);
    end
    tach_prev_d = tach_pulse_n;
    tach_irq_d = tach_prev_q & ~tach_pulse_n;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      relay_q <= 1'b0;
      tach_prev_q <= 1'b1;
      tach_irq_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
      tach_prev_q <= tach_prev_d;
      tach_irq_q <= tach_irq_d;
    end
  end

  assign segment_bus = bus_q;
  assign unit_enable = en_q;
  assign setpoint_relay = relay_q;
  assign tach_edge_interrupt = tach_irq_q;
  assign shared_port_digital = shared_port_pins;
  assign shared_port_analog = analog_mode;
  assign pressure_channel = CH_PRESSURE;
  assign temperature_channel = CH_TEMPERATURE;
  assign setpoint_channel = CH_SETPOINT;
  assign shown_param = param_q;
endmodule

// ---- testbench/tach_src.sv ----
// Purpose: turbine tachometer stand-in driving the flow pulse line
// Assumes: fire pulses spaced at least 20 cycles apart
// Notes: each fire gives one low cycle, well under a tenth of the spacing
`timescale 1ns/10ps
module tach_src (
  input wire logic core_clk,
  input wire logic fire,
  output logic tach_pulse_n
);
  initial tach_pulse_n = 1'b1;
  always @(posedge core_clk) tach_pulse_n <= !fire;
endmodule

// ---- testbench/panel_chk.sv ----
// Purpose: port checker for the front-panel block
// Assumes: one core_clk domain
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module panel_chk
  import panel_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [UNIT_COUNT-1:0] unit_enable,
  input wire logic setpoint_relay,
  input wire logic measure_done,
  input wire logic [ADC_WIDTH-1:0] airflow_value,
  input wire logic [ADC_WIDTH-1:0] setpoint_value,
  input wire logic tach_pulse_n,
  input wire logic tach_edge_interrupt,
  input wire logic [4:0] shared_port_pins,
  input wire logic [4:0] shared_port_digital,
  input wire logic analog_mode,
  input wire logic shared_port_analog,
  input wire logic [2:0] pressure_channel,
  input wire logic [2:0] temperature_channel,
  input wire logic [2:0] setpoint_channel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_enable_onehot: assert property ($onehot0(unit_enable)) else $error("two units enabled");
  a_blank_between: assert property (unit_enable != 4'h0 && $past(unit_enable) != 4'h0 |->
    $stable(unit_enable)) else $error("unit switched without blanking");
  a_scan_order: assert property (unit_enable == 4'h0 && $past(unit_enable) != 4'h0 |=>
    unit_enable == {$past(unit_enable[2:0], 2), $past(unit_enable[3], 2)}) else $error("scan order wrong");
  a_relay_compare: assert property (measure_done |=>
    setpoint_relay == $past(airflow_value > setpoint_value)) else $error("relay level wrong");
  a_relay_hold: assert property (!measure_done |=> $stable(setpoint_relay)) else $error("relay moved");
  a_tach_edge: assert property ($fell(tach_pulse_n) |=> tach_edge_interrupt ##1 !tach_edge_interrupt)
    else $error("tach pulse not reported once");
  a_port_copy: assert property (shared_port_digital == shared_port_pins &&
    shared_port_analog == analog_mode) else $error("shared port readback wrong");
  a_channel_map: assert property (pressure_channel == CH_PRESSURE && temperature_channel == CH_TEMPERATURE
    && setpoint_channel == CH_SETPOINT) else $error("channel map wrong");
  c_relay_on: cover property ($rose(setpoint_relay));
  c_tach_irq: cover property (tach_edge_interrupt);
  c_tens_on: cover property ($rose(unit_enable[EN_TENS]));
endmodule
bind front_panel_led_mux_io panel_chk chk (.core_clk, .nrst, .unit_enable, .setpoint_relay, .measure_done,
  .airflow_value, .setpoint_value, .tach_pulse_n, .tach_edge_interrupt, .shared_port_pins, .shared_port_digital,
  .analog_mode, .shared_port_analog, .pressure_channel, .temperature_channel, .setpoint_channel);

// ---- testbench/front_panel_led_mux_io_tb_top.sv ----
// Purpose: self-checking bench for the front-panel block
// Assumes: short scan and update counts
// Notes: segment patterns differ per parameter and digit
`timescale 1ns/10ps
module front_panel_led_mux_io_tb_top;
  import panel_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, btn_t_n = 1'b1, btn_p_n = 1'b1, fire = 1'b0, mode = 1'b0, mdone = 1'b0;
  logic tach_n, relay, irq, ana;
  logic [4:0] pins = 5'h00, dig;
  logic [7:0] segs [4][3], af = 8'h00, sp = 8'h00, bus;
  logic [3:0] en;
  logic [2:0] pch, tch, sch;
  param_e shown;
  int miscompares = 0, checked = 0, irqs = 0;
  always #2.5 core_clk = !core_clk;
  always @(posedge core_clk) if (irq === 1'b1) irqs++;
  tach_src tach (.core_clk(core_clk), .fire(fire), .tach_pulse_n(tach_n));
  front_panel_led_mux_io #(.SCAN_CYCLES(8), .UPDATE_CYCLES(4), .UPDATE_COUNT(4)) DUT (.core_clk(core_clk),
    .nrst(nrst), .temperature_select_button_n(btn_t_n), .pressure_select_button_n(btn_p_n), .tach_pulse_n(tach_n),
    .analog_mode(mode), .shared_port_pins(pins), .airflow_segments(segs[0]), .temperature_segments(segs[1]),
    .pressure_segments(segs[2]), .setpoint_segments(segs[3]), .airflow_value(af), .setpoint_value(sp),
    .measure_done(mdone), .segment_bus(bus), .unit_enable(en), .setpoint_relay(relay), .tach_edge_interrupt(irq),
    .shared_port_digital(dig), .shared_port_analog(ana), .pressure_channel(pch), .temperature_channel(tch),
    .setpoint_channel(sch), .shown_param(shown));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_en(input logic [3:0] e);
    int i;
    for (i = 0; i < 200 && en !== e; i++) cyc(1);
    chk({4'h0, en}, {4'h0, e});
  endtask
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic test_reset;
    int i;
    chk({3'h0, relay, en}, 8'h00);
    chk(bus, 8'h00);
    chk({6'h00, shown}, 8'h00);
    @(posedge core_clk) nrst <= 1'b1;
    for (i = 0; i < 50 && en === 4'h0; i++) cyc(1);
    chk({4'h0, en}, 8'h01);
    chk(bus, 8'h01);
    $display("test reset done");
  endtask
  task automatic test_buttons;
    int p;
    for (p = 0; p < 4; p++) begin
      @(posedge core_clk) {btn_p_n, btn_t_n} <= ~p[1:0];
      cyc(40);
      chk({6'h00, shown}, 8'(p));
      wait_en(4'h2);
      wait_en(4'h8);
      chk(bus, segs[p][2]);
      wait_en(4'h1);
      chk({4'h0, bus[3:0]}, 8'h01 << p);
    end
    @(posedge core_clk) {btn_p_n, btn_t_n} <= 2'b11;
    cyc(3);
    chk({6'h00, shown}, 8'h03);
    cyc(20);
    chk({6'h00, shown}, 8'h00);
    $display("test buttons done");
  endtask
  task automatic test_relay;
    logic [7:0] v [4] = '{8'h05, 8'h03, 8'h04, 8'h02};
    logic [3:0] want = 4'h5;
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk) {af, sp, mdone} <= {v[i], 8'h03, 1'b1};
      @(posedge core_clk) mdone <= 1'b0;
      #1 chk({7'h00, relay}, {7'h00, want[i]});
    end
    $display("test relay done");
  endtask
  task automatic test_tach;
    repeat (3) begin
      @(posedge core_clk) fire <= 1'b1;
      @(posedge core_clk) fire <= 1'b0;
      cyc(20);
    end
    chk(8'(irqs), 8'h03);
    @(posedge core_clk) {mode, pins} <= 6'h35;
    cyc(1);
    chk({2'h0, ana, dig}, 8'h35);
    chk({2'h0, pch, tch}, {2'h0, CH_PRESSURE, CH_TEMPERATURE});
    chk({5'h00, sch}, {5'h00, CH_SETPOINT});
    $display("test tach and ports done");
  endtask
  initial begin
    for (int p = 0; p < 4; p++) for (int d = 0; d < 3; d++) segs[p][d] <= 8'(8'h11 * (p + 1) + 8'h40 * d);
    cyc(5);
    test_reset;
    test_buttons;
    test_relay;
    test_tach;
    finish_test;
  end
  initial begin
    #100000;
    miscompares++;
    finish_test;
  end
endmodule
